// *** hdl/audio_fmt_ctrl.sv ***
// format control: axi4-lite registers, cable link receiver, aes3 mapping
// assumes link pins and aes status pins are asynchronous to clock
`timescale 1ns/10ps
`default_nettype none
module audio_fmt_ctrl (
    input wire logic clock,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // multichannel cable link, word clock carried with the data
    input wire logic link_clk,
    input wire logic link_sync,
    input wire logic link_data,
    // aes3 receiver channel-status report
    input wire logic [1:0] aes_cs_rate,
    input wire logic aes_cs_strobe,
    // outputs
    output logic [23:0] track_sample,
    output logic track_valid,
    output audio_fmt_pkg::aes_map_t aes_map,
    output logic cable_split,
    output logic [23:0] out_sample,
    output logic mismatch_warning,
    output logic irq
);
    typedef struct packed {
        audio_fmt_pkg::ctrl_t ctrl;
        logic [1:0] mask;
        logic [1:0] status;
        logic aw_held;
        logic w_held;
        logic [3:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] clk_sync;
        logic [1:0] sync_sync;
        logic [1:0] data_sync;
        logic [1:0] cs_sync0;
        logic [1:0] cs_sync1;
        logic [2:0] strobe_sync;
        logic [23:0] shift;
        logic [4:0] bit_cnt;
        logic [23:0] sample;
        logic valid;
        logic mismatch_live;
        logic warning;
        logic irq;
        audio_fmt_pkg::aes_map_t map;
        logic split;
        logic [23:0] out;
    } state_t;

    state_t s;
    state_t next_s;
    logic [23:0] tone_sample;
    logic word_done;
    logic [23:0] masked;
    logic [1:0] expect_rate;
    logic [1:0] events;

    // zero the low bits the chosen word length does not carry
    function automatic logic [23:0] trim(input logic [23:0] w, input audio_fmt_pkg::in_width_t l);
        case (l)
            audio_fmt_pkg::in_w16: trim = {w[23:8], 8'h00};
            audio_fmt_pkg::in_w20: trim = {w[23:4], 4'h0};
            default: trim = w;
        endcase
    endfunction : trim

    // register address decode, used for the write and read error responses
    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == audio_fmt_pkg::ctrl_off) || (a == audio_fmt_pkg::status_off) ||
                 (a == audio_fmt_pkg::mask_off) || (a == audio_fmt_pkg::live_off);
    endfunction : mapped

    // last count of a word; the counter parks here between words
    function automatic logic [4:0] bit_cnt_max();
        bit_cnt_max = audio_fmt_pkg::word_bits;
    endfunction : bit_cnt_max

    sine_tone tone_gen (
        .clock(clock),
        .rst(rst),
        .tick(word_done),
        .sel(s.ctrl.tone),
        .sample(tone_sample)
    );

    // a word ends on the link clock edge that shifts in its 24th bit
    assign word_done = s.clk_sync[1] && !s.clk_sync[2] &&
                       (s.sync_sync[1] ? 1'b0 : s.bit_cnt == audio_fmt_pkg::word_bits - 5'h01);
    assign masked = trim({s.shift[22:0], s.data_sync[1]}, s.ctrl.in_width);
    // expected channel-status rate follows the active mapping
    assign expect_rate = s.map.high_speed ? audio_fmt_pkg::cs_high_speed :
                         s.map.dual_line ? audio_fmt_pkg::cs_dual_line : audio_fmt_pkg::cs_base;

    always_comb begin
        next_s = s;
        events = 2'h0;
        // pin synchronisers, link clock edges found from the second stage onward
        next_s.clk_sync = {s.clk_sync[1:0], link_clk};
        next_s.sync_sync = {s.sync_sync[0], link_sync};
        next_s.data_sync = {s.data_sync[0], link_data};
        next_s.cs_sync0 = aes_cs_rate;
        next_s.cs_sync1 = s.cs_sync0;
        next_s.strobe_sync = {s.strobe_sync[1:0], aes_cs_strobe};

        // cable link receiver, msb first, sync marks the first bit
        next_s.valid = 1'b0;
        if (s.clk_sync[1] && !s.clk_sync[2]) begin
            next_s.shift = {s.shift[22:0], s.data_sync[1]};
            if (s.sync_sync[1]) begin
                next_s.bit_cnt = audio_fmt_pkg::bit_cnt_one;
            end else if (word_done) begin
                next_s.bit_cnt = bit_cnt_max(); // park: stray bits wait for sync
                next_s.valid = 1'b1;
                events[audio_fmt_pkg::ev_word] = 1'b1;
                // tone overrides every source while it runs
                if (s.ctrl.tone != audio_fmt_pkg::tone_off) begin
                    next_s.sample = tone_sample;
                end else begin
                    next_s.sample = masked;
                end
            end else if (s.bit_cnt != bit_cnt_max()) begin
                next_s.bit_cnt = s.bit_cnt + audio_fmt_pkg::bit_cnt_one;
            end
        end

        // one mapping for all aes channels, gated by the four-track setting
        next_s.map.base_map = !s.ctrl.quad_rate;
        next_s.map.high_speed = s.ctrl.quad_rate && s.ctrl.high_speed;
        next_s.map.dual_line = s.ctrl.quad_rate && !s.ctrl.high_speed;
        next_s.split = 1'b1;
        // output width: 24 bits only with a high-resolution recording
        next_s.out = (s.ctrl.out24 && s.ctrl.hr_rec) ? s.sample
                                                     : {s.sample[23:8], 8'h00};

        // channel-status check on each report from the aes3 receiver
        if (s.strobe_sync[1] && !s.strobe_sync[2]) begin
            next_s.mismatch_live = (s.cs_sync1 != expect_rate);
            events[audio_fmt_pkg::ev_mismatch] = (s.cs_sync1 != expect_rate);
        end
        next_s.warning = next_s.mismatch_live && !s.ctrl.silent;

        // axi write channels taken in either order
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(s.awaddr) ? audio_fmt_pkg::resp_okay
                                            : audio_fmt_pkg::resp_slverr;
            // only byte lane 0 and 1 hold bits; status is read-only
            if (s.awaddr == audio_fmt_pkg::ctrl_off) begin
                if (s.wstrb[0]) begin
                    next_s.ctrl[7:0] = s.wdata[7:0];
                end
                if (s.wstrb[1]) begin
                    next_s.ctrl[8] = s.wdata[8];
                end
            end else if (s.awaddr == audio_fmt_pkg::mask_off && s.wstrb[0]) begin
                next_s.mask = s.wdata[1:0];
            end
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;

        // axi read, status clears on read but a same-cycle event survives
        next_s.status = s.status | events;
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = mapped(s_axi_araddr) ? audio_fmt_pkg::resp_okay
                                                : audio_fmt_pkg::resp_slverr;
            case (s_axi_araddr)
                audio_fmt_pkg::ctrl_off: next_s.rdata = {23'h000000, s.ctrl};
                audio_fmt_pkg::status_off: begin
                    next_s.rdata = {30'h00000000, s.status};
                    next_s.status = events;
                end
                audio_fmt_pkg::mask_off: next_s.rdata = {30'h00000000, s.mask};
                audio_fmt_pkg::live_off: next_s.rdata = {4'h0, s.map, s.mismatch_live, s.sample};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        next_s.arready = !next_s.rvalid;
        next_s.irq = |(next_s.status & s.mask);
    end

    // whole state registered in one place
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
            s.ctrl <= audio_fmt_pkg::ctrl_reset;
            s.map.base_map <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign track_sample = s.sample;
    assign track_valid = s.valid;
    assign aes_map = s.map;
    assign cable_split = s.split;
    assign out_sample = s.out;
    assign mismatch_warning = s.warning;
    assign irq = s.irq;

    // all checks on the system clock, quiet while reset is held
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // trimmed low byte for 16-bit input when the tone is off
    a_trim_sixteen: assert property (
        (word_done && s.ctrl.in_width == audio_fmt_pkg::in_w16 &&
         s.ctrl.tone == audio_fmt_pkg::tone_off) |=> (track_sample[7:0] == 8'h00 && track_valid))
        else $error("16-bit input word kept low bits");
    a_trim_twenty: assert property (
        (word_done && s.ctrl.in_width == audio_fmt_pkg::in_w20 &&
         s.ctrl.tone == audio_fmt_pkg::tone_off) |=> track_sample[3:0] == 4'h0)
        else $error("20-bit input word kept low bits");
    a_single_method: assert property (
        !(aes_map.dual_line && aes_map.high_speed) && (aes_map.base_map != (aes_map.dual_line ||
        aes_map.high_speed)))
        else $error("aes channels not on one method");
    a_mode_gated: assert property (
        $past(!s.ctrl.quad_rate) |-> aes_map.base_map)
        else $error("transfer mode used outside four-track");
    a_high_speed_map: assert property (
        (s.ctrl.quad_rate && s.ctrl.high_speed) |=> aes_map.high_speed)
        else $error("high speed not applied");
    a_dual_line_map: assert property (
        (s.ctrl.quad_rate && !s.ctrl.high_speed) |=> aes_map.dual_line)
        else $error("dual line not applied");
    a_cable_split: assert property (!$past(rst) |-> cable_split)
        else $error("cable link not split");
    a_warn_silent: assert property (
        s.ctrl.silent |=> !mismatch_warning)
        else $error("warning shown while silent");
    a_warn_normal: assert property (
        (s.strobe_sync[1] && !s.strobe_sync[2] && s.cs_sync1 != expect_rate && !s.ctrl.silent)
        ##1 !s.ctrl.silent |=> mismatch_warning)
        else $error("mismatch gave no warning");
    a_sticky_flag: assert property (
        (s.status[audio_fmt_pkg::ev_mismatch] && !(s_axi_arvalid && s.arready))
        |=> s.status[audio_fmt_pkg::ev_mismatch])
        else $error("mismatch flag lost without a read");
    a_tone_override: assert property (
        (word_done && s.ctrl.tone != audio_fmt_pkg::tone_off)
        |=> track_sample == $past(tone_sample))
        else $error("tone did not replace input");
    a_out_width: assert property (
        !(s.ctrl.out24 && s.ctrl.hr_rec) ##1 !(s.ctrl.out24 && s.ctrl.hr_rec)
        |-> out_sample[7:0] == 8'h00)
        else $error("24-bit output without hr");

    // flag, live report, pulse, interrupt, 24-bit lsb, silent audio and full output checks
    a_mismatch_flag: assert property (
        (s.strobe_sync[1] && !s.strobe_sync[2] && s.cs_sync1 != expect_rate)
        |=> s.status[audio_fmt_pkg::ev_mismatch])
        else $error("mismatch did not set the flag");
    a_live_report: assert property (
        (s.strobe_sync[1] && !s.strobe_sync[2])
        |=> s.mismatch_live == $past(s.cs_sync1 != expect_rate))
        else $error("live mismatch does not follow the report");
    a_valid_pulse: assert property (track_valid |=> !track_valid)
        else $error("track_valid held past one cycle");
    a_irq_level: assert property (irq == |(s.status & $past(s.mask)))
        else $error("irq does not follow status and mask");
    a_lsb_kept: assert property (
        (word_done && s.ctrl.in_width == audio_fmt_pkg::in_w24 &&
         s.ctrl.tone == audio_fmt_pkg::tone_off) |=> track_sample[0] == $past(s.data_sync[1]))
        else $error("24-bit input lost its last bit");
    a_silent_audio: assert property ((word_done && s.ctrl.silent) |=> track_valid)
        else $error("silent check setting stopped audio");
    a_out_full: assert property (
        (s.ctrl.out24 && s.ctrl.hr_rec) |=> out_sample == $past(s.sample))
        else $error("24-bit output not passed whole");
endmodule : audio_fmt_ctrl
`default_nettype wire

// *** hdl/audio_fmt_pkg.sv ***
// constants, field layouts and carriers for the digital audio format control
// assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data
package audio_fmt_pkg;
    // register byte offsets
    localparam logic [3:0] ctrl_off = 4'h0;
    localparam logic [3:0] status_off = 4'h4;
    localparam logic [3:0] mask_off = 4'h8;
    localparam logic [3:0] live_off = 4'hc;
    localparam int addr_w = 4;
    // control field positions
    localparam int f_in_width = 0; // two bits
    localparam int f_high_speed = 2;
    localparam int f_quad_rate = 3;
    localparam int f_silent = 4;
    localparam int f_tone = 5; // two bits
    localparam int f_out24 = 7;
    localparam int f_hr_rec = 8;
    localparam int ctrl_w = 9;
    localparam logic [8:0] ctrl_reset = 9'h000;
    // status / mask bit positions
    localparam int ev_mismatch = 0;
    localparam int ev_word = 1;
    localparam int ev_w = 2;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // sample widths
    localparam int sample_w = 24;
    localparam logic [4:0] word_bits = 5'h18;
    localparam logic [4:0] bit_cnt_zero = 5'h00;
    localparam logic [4:0] bit_cnt_one = 5'h01;
    // channel-status rate codes carried by the aes receiver
    localparam logic [1:0] cs_base = 2'h0;
    localparam logic [1:0] cs_high_speed = 2'h1;
    localparam logic [1:0] cs_dual_line = 2'h2;
    // tone generator: word rate, tone frequencies and phase steps
    localparam int word_rate_hz = 48000;
    localparam int tone_a_hz = 440;
    localparam int tone_b_hz = 1000;
    localparam int phase_w = 24;
    localparam logic [23:0] step_a = 24'(64'(tone_a_hz) * 64'(1 << phase_w) / word_rate_hz);
    localparam logic [23:0] step_b = 24'(64'(tone_b_hz) * 64'(1 << phase_w) / word_rate_hz);

    typedef enum logic [1:0] {in_w16, in_w20, in_w24, in_wres} in_width_t;
    typedef enum logic [1:0] {tone_off, tone_440, tone_1k, tone_res} tone_sel_t;

    // software-visible configuration
    typedef struct packed {
        logic hr_rec;
        logic out24;
        tone_sel_t tone;
        logic silent;
        logic quad_rate;
        logic high_speed;
        in_width_t in_width;
    } ctrl_t;

    // what the aes3 side is told to do
    typedef struct packed {
        logic dual_line;
        logic high_speed;
        logic base_map;
    } aes_map_t;
endpackage : audio_fmt_pkg

// *** hdl/sine_tone.sv ***
// test-tone source: sine at nominal level, one sample per word tick
// assumes tick is a one-cycle pulse at the word rate from the same clock
`timescale 1ns/10ps
`default_nettype none
module sine_tone (
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire audio_fmt_pkg::tone_sel_t sel,
    output logic [23:0] sample
);
    // sixteen-point cycle, quarter table, amplitude sits at the nominal level
    function automatic logic [23:0] quarter(input logic [1:0] i);
        case (i)
            2'h0: quarter = 24'h000000;
            2'h1: quarter = 24'h07c375;
            2'h2: quarter = 24'h0e585e;
            2'h3: quarter = 24'h12be3b;
            default: quarter = 24'h000000;
        endcase
    endfunction : quarter

    logic [23:0] phase;
    logic [3:0] idx;
    logic [23:0] mag;

    // fold the quarter table into a full cycle
    always_comb begin
        idx = phase[23:20];
        if (idx[2:0] == 3'h4) begin
            mag = 24'h14497f;
        end else if (idx[2]) begin
            mag = quarter(2'(3'h4 - {1'b0, idx[1:0]}));
        end else begin
            mag = quarter(idx[1:0]);
        end
    end

    // phase advances only on word ticks; off parks the phase at zero
    always_ff @(posedge clock) begin
        if (rst || sel == audio_fmt_pkg::tone_off) begin
            phase <= 24'h000000;
            sample <= 24'h000000;
        end else if (tick) begin
            phase <= phase + ((sel == audio_fmt_pkg::tone_1k) ? audio_fmt_pkg::step_b
                                                              : audio_fmt_pkg::step_a);
            sample <= idx[3] ? 24'(24'h000000 - mag) : mag;
        end
    end
endmodule : sine_tone
`default_nettype wire

// *** sim/link_source.sv ***
// cable-link far side: sends 24-bit words msb first, sync on the first bit
// assumes the bench calls send_word; the link clock stands still between words
`timescale 1ns/10ps
`default_nettype none
module link_source (
    output logic link_clk,
    output logic link_sync,
    output logic link_data
);
    // idle state before the first word
    initial begin
        link_clk = 1'b0;
        link_sync = 1'b0;
        link_data = 1'b0;
    end

    // 80 ns bit period, 7 ns off the system clock grid so phases differ
    // the word clock rides with the data, no separate clock line
    // this end is the one word-clock master; the block only follows it
    task automatic send_word(input logic [23:0] w);
        #7;
        for (int i = 23; i >= 0; i--) begin
            link_data = w[i];
            link_sync = (i == 23);
            #40;
            link_clk = 1'b1;
            #40;
            link_clk = 1'b0;
        end
        // released line shows the inverse, not a stale copy of the last bit
        link_sync = 1'b0;
        link_data = ~w[0];
    endtask : send_word
endmodule : link_source
`default_nettype wire

// *** sim/audio_fmt_ctrl_bench.sv ***
// self-checking bench for the digital audio format control block
// assumes link_source on the cable link; bench drives axi and aes status pins
`timescale 1ns/10ps
`default_nettype none
module audio_fmt_ctrl_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, link_clk, link_sync, link_data;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [1:0] cs_rate = 2'h0;
    logic cs_strobe = 1'b0;
    logic [23:0] track_sample, out_sample, msk;
    logic track_valid, cable_split, mismatch_warning, irq;
    audio_fmt_pkg::aes_map_t aes_map;
    int n_fail = 0;
    int checked = 0;

    // 100 MHz system clock
    always #5 clock = ~clock;

    audio_fmt_ctrl audio_fmt_ctrl_inst (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .link_clk(link_clk), .link_sync(link_sync), .link_data(link_data),
        .aes_cs_rate(cs_rate), .aes_cs_strobe(cs_strobe),
        .track_sample(track_sample), .track_valid(track_valid), .aes_map(aes_map),
        .cable_split(cable_split), .out_sample(out_sample),
        .mismatch_warning(mismatch_warning), .irq(irq)
    );

    link_source link_source_inst (
        .link_clk(link_clk), .link_sync(link_sync), .link_data(link_data)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // both channels offered together, each released when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (!aw_done && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end while (!(aw_done && w_done && bvalid === 1'b1));
        rsp = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a);
        logic ar_done;
        ar_done = 1'b0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (!ar_done && arready === 1'b1) begin
                arvalid <= 1'b0;
                ar_done = 1'b1;
            end
        end while (!(ar_done && rvalid === 1'b1));
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : axi_read

    // one word over the link; waits, bounded, for the track_valid pulse
    task automatic word(input logic [23:0] w);
        int n;
        n = 0;
        fork
            link_source_inst.send_word(w);
            begin
                do begin
                    @(posedge clock);
                    n++;
                end while (track_valid !== 1'b1 && n < 400);
            end
        join
        check("track_valid", 32'(n < 400), 32'h1);
    endtask : word

    // rate code held steady well around the strobe edge
    task automatic cs(input logic [1:0] r);
        @(posedge clock);
        cs_rate <= r;
        repeat (4) @(posedge clock);
        cs_strobe <= 1'b1;
        repeat (4) @(posedge clock);
        cs_strobe <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : cs

    // watchdog: the whole sequence needs well under 10k cycles
    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    // main test sequence
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check("cable_split", 32'(cable_split), 32'h1);
        axi_read(audio_fmt_pkg::ctrl_off);
        check("ctrl reset", rd, 32'(audio_fmt_pkg::ctrl_reset));
        axi_write(audio_fmt_pkg::ctrl_off, 32'h1b5);
        check("bresp", 32'(rsp), 32'(audio_fmt_pkg::resp_okay));
        axi_read(audio_fmt_pkg::ctrl_off);
        check("ctrl readback", rd, 32'h1b5);
        $display("test registers done");
        // every width setting, 3 reads as 24; 16 also suits older sources
        for (int i = 0; i < 4; i++) begin
            axi_write(audio_fmt_pkg::ctrl_off, 32'(i));
            word(24'habcdef);
            msk = (i == 0) ? 24'hffff00 : ((i == 1) ? 24'hfffff0 : 24'hffffff);
            check("track_sample", 32'(track_sample), 32'(24'habcdef & msk));
            check("out_sample 16", 32'(out_sample), 32'h00abcd00);
            axi_read(audio_fmt_pkg::live_off);
            check("live sample", rd & 32'hffffff, 32'(24'habcdef & msk));
        end
        // 24-bit output only with out24 and a high-resolution recording
        for (int j = 0; j < 3; j++) begin
            axi_write(audio_fmt_pkg::ctrl_off,
                      32'h2 | (j == 0 ? 32'h0 : 32'h80) | (j == 2 ? 32'h100 : 32'h0));
            word(24'h5a5a5a);
            check("out_sample", 32'(out_sample), (j == 2) ? 32'h5a5a5a : 32'h5a5a00);
        end
        axi_read(audio_fmt_pkg::status_off);
        check("status word", rd, 32'h2);
        axi_read(audio_fmt_pkg::status_off);
        check("status cleared", rd, 32'h0);
        $display("test widths done");
        // quad_rate by high_speed, one method for all channels
        for (int k = 0; k < 4; k++) begin
            axi_write(audio_fmt_pkg::ctrl_off, 32'(k) << 2);
            repeat (2) @(posedge clock);
            msk = (k < 2) ? 24'h1 : ((k == 3) ? 24'h2 : 24'h4);
            check("aes_map", 32'(aes_map), 32'(msk));
            axi_read(audio_fmt_pkg::live_off);
            check("live aes_map", (rd >> 25) & 32'h7, 32'(msk));
        end
        $display("test aes map done");
        // mismatch with check normal, then matching, then silent
        axi_write(audio_fmt_pkg::ctrl_off, 32'h2);
        axi_write(audio_fmt_pkg::mask_off, 32'h1);
        cs(audio_fmt_pkg::cs_high_speed);
        check("warning normal", 32'(mismatch_warning), 32'h1);
        check("irq set", 32'(irq), 32'h1);
        axi_read(audio_fmt_pkg::status_off);
        check("status mismatch", rd & 32'h1, 32'h1);
        repeat (3) @(posedge clock);
        check("irq cleared", 32'(irq), 32'h0);
        cs(audio_fmt_pkg::cs_base);
        check("warning match", 32'(mismatch_warning), 32'h0);
        axi_write(audio_fmt_pkg::ctrl_off, 32'ha);
        cs(audio_fmt_pkg::cs_dual_line);
        check("warning dual", 32'(mismatch_warning), 32'h0);
        axi_write(audio_fmt_pkg::ctrl_off, 32'he);
        cs(audio_fmt_pkg::cs_high_speed);
        check("warning speed", 32'(mismatch_warning), 32'h0);
        axi_write(audio_fmt_pkg::ctrl_off, 32'h12);
        axi_write(audio_fmt_pkg::mask_off, 32'h2);
        cs(audio_fmt_pkg::cs_high_speed);
        check("warning silent", 32'(mismatch_warning), 32'h0);
        check("irq masked", 32'(irq), 32'h0);
        word(24'h123456);
        check("silent audio", 32'(track_sample), 32'h123456);
        check("irq word", 32'(irq), 32'h1);
        axi_read(audio_fmt_pkg::status_off);
        check("status silent", rd, 32'h3);
        $display("test status check done");
        // tone replaces the link sample for both frequencies
        for (int t = 1; t < 3; t++) begin
            axi_write(audio_fmt_pkg::ctrl_off, 32'h2 | (32'(t) << 5));
            word(24'habcdef);
            word(24'habcdef);
            check("tone replaces", 32'(track_sample !== 24'habcdef), 32'h1);
        end
        axi_write(audio_fmt_pkg::ctrl_off, 32'h2);
        word(24'habcdef);
        check("tone off", 32'(track_sample), 32'habcdef);
        $display("test tone done");
        close_out();
    end
endmodule : audio_fmt_ctrl_bench
`default_nettype wire
